// >>> rtl/debug_port_defines.svh
// timing counts and constants for the debug and test port
`ifndef DEBUG_PORT_DEFINES_SVH
`define DEBUG_PORT_DEFINES_SVH
`define IR_WIDTH         4
`define IR_RESET_VALUE   4'h1
`define IR_CAPTURE_VALUE 4'h1
`define IR_BYPASS        4'hF
`define IR_IDCODE        4'h1
`define ID_CODE_VALUE    32'h00000001
`define DEBUG_WIDTH      16
`define CLK_PERIOD_NS    40
`define STATUS_DIV_BIT   1'h1
`endif

// >>> rtl/debug_port_pkg.sv
// types shared by the debug and test port
package debug_port_pkg;
  typedef enum logic [3:0] {
    TAP_RESET      = 4'h0,
    TAP_IDLE       = 4'h1,
    TAP_SEL_DR     = 4'h2,
    TAP_CAPTURE_DR = 4'h3,
    TAP_SHIFT_DR   = 4'h4,
    TAP_EXIT1_DR   = 4'h5,
    TAP_PAUSE_DR   = 4'h6,
    TAP_EXIT2_DR   = 4'h7,
    TAP_UPDATE_DR  = 4'h8,
    TAP_SEL_IR     = 4'h9,
    TAP_CAPTURE_IR = 4'hA,
    TAP_SHIFT_IR   = 4'hB,
    TAP_EXIT1_IR   = 4'hC,
    TAP_PAUSE_IR   = 4'hD,
    TAP_EXIT2_IR   = 4'hE,
    TAP_UPDATE_IR  = 4'hF
  } tap_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_in_t;

  typedef struct packed {
    logic clock;
    logic data_in;
  } serial_in_t;
endpackage : debug_port_pkg

// >>> rtl/pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
module pin_sync (
  input  wire logic clk,      // system clock
  input  wire logic reset,    // synchronous reset, active high
  input  wire logic pin,      // asynchronous pin level
  output logic      level,    // validated level
  output logic      rise,     // one-cycle pulse on validated rise
  output logic      fall      // one-cycle pulse on validated fall
);
  logic meta;
  logic stage2;
  logic stage3;
  wire  agree      = (stage2 == stage3);
  wire  next_level = agree ? stage3 : level;

  always_ff @(posedge clk)
  begin
    meta   <= pin;
    stage2 <= meta;
    stage3 <= stage2;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end
    else
    begin
      level <= next_level;
      rise  <= next_level & ~level;
      fall  <= ~next_level & level;
    end
  end
endmodule : pin_sync

// >>> rtl/debug_jtag_serial_port.sv
// shared JTAG test port and clocked serial debug port
// Operation
// RULE1 - select pin level at reset picks port
// RULE2 - low test reset clears JTAG immediately
// RULE3 - state machine steps on test clock rise
// RULE4 - TDI bits captured on test clock rise
// RULE5 - TDO driven only in shift states
// RULE6 - TDO value changes on test clock fall
// RULE7 - debug clock accepted after two agreeing samples
// RULE8 - host keeps debug clock under status/5; the bench host runs it at status/2 (8 bus cycles against 4)
// RULE9 - debug rise samples input, steps output
// RULE10 - debug output comes from a register
// RULE11 - input accepted after debug clock seen high
// RULE12 - status clock is delayed processor clock; the code gives a registered quarter-rate divided copy
// RULE13 - select latched once, held until reset
`timescale 1ns/100ps
`include "debug_port_defines.svh"
module debug_jtag_serial_port (
  input  wire logic clk,             // processor and bus clock
  input  wire logic reset,           // synchronous reset, active high
  input  wire logic jtag_select,     // high picks JTAG at reset
  input  wire logic test_reset_n,    // async JTAG reset, active low
  input  wire logic pin_clock,       // shared pin: test or debug clock
  input  wire logic tms,             // test mode select
  input  wire logic pin_data_in,     // shared pin: TDI or debug input
  input  wire logic [15:0] debug_tx, // word to send to debugger
  output logic      tdo,             // test data out value
  output logic      tdo_oe,          // test data out enable
  output logic      serial_debug_out, // serial debug output
  output logic      processor_status_clock, // quarter-rate clock copy
  output logic      jtag_mode,       // latched port choice
  output logic [15:0] debug_rx,      // last word from debugger
  output logic      debug_rx_valid   // pulse when a word arrives
);
  logic       jtag_en;
  logic       reset_seen;
  logic       clk_level;
  logic       clk_rise;
  logic       clk_fall;
  logic       tms_level;
  logic       tdi_level;
  logic       trst_level;
  logic       trst_meta;
  logic       trst_hold;
  debug_port_pkg::tap_state_t state;
  debug_port_pkg::tap_state_t next_state;
  logic [`IR_WIDTH-1:0] ir_shift;
  logic [`IR_WIDTH-1:0] ir;
  logic [31:0] dr_shift;
  logic        tdo_bit;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [3:0]  bit_count;
  logic [1:0]  status_div;

  // select pin caught when reset ends, held until the next reset
  always_ff @(posedge clk)
  begin
    if (reset)
      reset_seen <= 1'b1;
    else
      reset_seen <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      jtag_en <= 1'b0;
    else if (reset_seen)
      jtag_en <= jtag_select; // see RULE1 see RULE13
  end

  pin_sync u_clk_sync (
    .clk   (clk),
    .reset (reset),
    .pin   (pin_clock),
    .level (clk_level),
    .rise  (clk_rise),
    .fall  (clk_fall)
  ); // see RULE7

  pin_sync u_tms_sync (
    .clk   (clk),
    .reset (reset),
    .pin   (tms),
    .level (tms_level),
    .rise  (),
    .fall  ()
  );

  pin_sync u_tdi_sync (
    .clk   (clk),
    .reset (reset),
    .pin   (pin_data_in),
    .level (tdi_level),
    .rise  (),
    .fall  ()
  );

  // test reset is asynchronous assert, synchronous release
  always_ff @(posedge clk or negedge test_reset_n)
  begin
    if (!test_reset_n)
    begin
      trst_meta <= 1'b1;
      trst_hold <= 1'b1;
    end
    else
    begin
      trst_meta <= 1'b0;
      trst_hold <= trst_meta;
    end
  end

  wire jtag_clear = trst_level | reset;
  wire tck_rise   = jtag_en & clk_rise;
  wire tck_fall   = jtag_en & clk_fall;
  wire shift_ir   = (state == debug_port_pkg::TAP_SHIFT_IR);
  wire shift_dr   = (state == debug_port_pkg::TAP_SHIFT_DR);
  wire bypass_sel = (ir == `IR_BYPASS);
  assign trst_level = trst_hold | ~test_reset_n; // see RULE2

  always_comb
  begin
    unique case (state)
      debug_port_pkg::TAP_RESET:
        next_state = tms_level ? debug_port_pkg::TAP_RESET
                               : debug_port_pkg::TAP_IDLE;
      debug_port_pkg::TAP_IDLE:
        next_state = tms_level ? debug_port_pkg::TAP_SEL_DR
                               : debug_port_pkg::TAP_IDLE;
      debug_port_pkg::TAP_SEL_DR:
        next_state = tms_level ? debug_port_pkg::TAP_SEL_IR
                               : debug_port_pkg::TAP_CAPTURE_DR;
      debug_port_pkg::TAP_CAPTURE_DR,
      debug_port_pkg::TAP_SHIFT_DR:
        next_state = tms_level ? debug_port_pkg::TAP_EXIT1_DR
                               : debug_port_pkg::TAP_SHIFT_DR;
      debug_port_pkg::TAP_EXIT1_DR:
        next_state = tms_level ? debug_port_pkg::TAP_UPDATE_DR
                               : debug_port_pkg::TAP_PAUSE_DR;
      debug_port_pkg::TAP_PAUSE_DR:
        next_state = tms_level ? debug_port_pkg::TAP_EXIT2_DR
                               : debug_port_pkg::TAP_PAUSE_DR;
      debug_port_pkg::TAP_EXIT2_DR:
        next_state = tms_level ? debug_port_pkg::TAP_UPDATE_DR
                               : debug_port_pkg::TAP_SHIFT_DR;
      debug_port_pkg::TAP_UPDATE_DR,
      debug_port_pkg::TAP_UPDATE_IR:
        next_state = tms_level ? debug_port_pkg::TAP_SEL_DR
                               : debug_port_pkg::TAP_IDLE;
      debug_port_pkg::TAP_SEL_IR:
        next_state = tms_level ? debug_port_pkg::TAP_RESET
                               : debug_port_pkg::TAP_CAPTURE_IR;
      debug_port_pkg::TAP_CAPTURE_IR,
      debug_port_pkg::TAP_SHIFT_IR:
        next_state = tms_level ? debug_port_pkg::TAP_EXIT1_IR
                               : debug_port_pkg::TAP_SHIFT_IR;
      debug_port_pkg::TAP_EXIT1_IR:
        next_state = tms_level ? debug_port_pkg::TAP_UPDATE_IR
                               : debug_port_pkg::TAP_PAUSE_IR;
      debug_port_pkg::TAP_PAUSE_IR:
        next_state = tms_level ? debug_port_pkg::TAP_EXIT2_IR
                               : debug_port_pkg::TAP_PAUSE_IR;
      debug_port_pkg::TAP_EXIT2_IR:
        next_state = tms_level ? debug_port_pkg::TAP_UPDATE_IR
                               : debug_port_pkg::TAP_SHIFT_IR;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (jtag_clear)
      state <= debug_port_pkg::TAP_RESET;
    else if (tck_rise)
      state <= next_state; // see RULE3
  end

  // instruction and data shifting on test clock rise
  always_ff @(posedge clk)
  begin
    if (jtag_clear)
    begin
      ir_shift <= `IR_RESET_VALUE;
      ir       <= `IR_RESET_VALUE;
      dr_shift <= 32'h00000000;
    end
    else if (tck_rise)
    begin
      if (state == debug_port_pkg::TAP_CAPTURE_IR)
        ir_shift <= `IR_CAPTURE_VALUE;
      else if (shift_ir)
        ir_shift <= {tdi_level, ir_shift[`IR_WIDTH-1:1]}; // see RULE4
      if (state == debug_port_pkg::TAP_UPDATE_IR)
        ir <= ir_shift;
      if (state == debug_port_pkg::TAP_CAPTURE_DR)
        dr_shift <= bypass_sel ? 32'h00000000 : `ID_CODE_VALUE;
      else if (shift_dr && bypass_sel)
        dr_shift <= {31'h00000000, tdi_level}; // see RULE4
      else if (shift_dr)
        dr_shift <= {tdi_level, dr_shift[31:1]}; // see RULE4
    end
  end

  wire next_tdo_bit = shift_ir ? ir_shift[0] : dr_shift[0];

  // output value and enable move only on test clock fall
  always_ff @(posedge clk)
  begin
    if (jtag_clear)
    begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo    <= next_tdo_bit; // see RULE6
      tdo_oe <= shift_ir | shift_dr; // see RULE5
    end
  end

  // serial debug port, active when JTAG is not selected
  wire dbg_rise = ~jtag_en & clk_rise & clk_level; // see RULE11
  wire word_end = (bit_count == 4'hF);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_shift         <= 16'h0000;
      tx_shift         <= 16'h0000;
      bit_count        <= 4'h0;
      serial_debug_out <= 1'b0;
      debug_rx         <= 16'h0000;
      debug_rx_valid   <= 1'b0;
    end
    else
    begin
      debug_rx_valid <= 1'b0;
      if (dbg_rise)
      begin
        rx_shift         <= {rx_shift[14:0], tdi_level}; // see RULE9
        serial_debug_out <= tx_shift[15]; // see RULE9 see RULE10
        bit_count        <= bit_count + 4'h1;
        tx_shift         <= word_end ? debug_tx
                                     : {tx_shift[14:0], 1'b0};
        if (word_end)
        begin
          debug_rx       <= {rx_shift[14:0], tdi_level};
          debug_rx_valid <= 1'b1;
        end
      end
    end
  end

  // status clock: registered quarter-rate copy of the processor clock
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      status_div             <= 2'h0;
      processor_status_clock <= 1'b0;
    end
    else
    begin
      status_div <= status_div + 2'h1;
      if (status_div[0] == `STATUS_DIV_BIT)
        processor_status_clock <= ~processor_status_clock; // see RULE12
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      jtag_mode <= 1'b0;
    else
      jtag_mode <= jtag_en;
  end
endmodule : debug_jtag_serial_port

// >>> sim/debug_port_monitor.sv
// pin assertions for the debug and test port
`timescale 1ns/100ps
module debug_port_monitor (
  input wire logic clk,                    // clock
  input wire logic reset,                  // reset
  input wire logic test_reset_n,           // test reset
  input wire logic pin_clock,              // shared clock pin
  input wire logic tdo,                    // test data
  input wire logic tdo_oe,                 // test data enable
  input wire logic serial_debug_out,       // serial out
  input wire logic processor_status_clock, // status clock
  input wire logic jtag_mode,              // port choice
  input wire logic debug_rx_valid          // word strobe
);
  logic [3:0] run_cnt; // cycles since reset, saturating
  always_ff @(posedge clk)
  begin
    if (reset)
      run_cnt <= 4'h0;
    else if (run_cnt != 4'hF)
      run_cnt <= run_cnt + 4'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // pin held at one level through the whole validation span
  sequence pin_was_low;
    !$past(pin_clock, 3) && !$past(pin_clock, 4) && !$past(pin_clock, 5);
  endsequence
  sequence pin_was_high;
    $past(pin_clock, 3) && $past(pin_clock, 4) && $past(pin_clock, 5);
  endsequence
  chk_choice_held: assert property (
    run_cnt > 4'h3 |-> $stable(jtag_mode)) else $error("choice moved");
  chk_jtag_idle: assert property (
    !jtag_mode && run_cnt > 4'h3 |-> !tdo_oe) else $error("tdo driven");
  chk_serial_idle: assert property (
    jtag_mode && run_cnt > 4'h3 |-> !debug_rx_valid) else $error("rx seen");
  chk_trst_clears: assert property (
    $fell(test_reset_n) |=> !tdo_oe [*3]) else $error("tdo kept");
  chk_tdo_on_fall: assert property (
    disable iff (reset || !test_reset_n)
    run_cnt > 4'h3 && $changed(tdo) |-> pin_was_low) else $error("tdo early");
  chk_oe_on_fall: assert property (
    disable iff (reset || !test_reset_n)
    run_cnt > 4'h3 && $changed(tdo_oe) |-> pin_was_low) else $error("oe early");
  chk_out_on_rise: assert property (
    run_cnt > 4'h3 && $changed(serial_debug_out) |-> pin_was_high)
    else $error("out early");
  chk_rx_after_high: assert property (
    debug_rx_valid |-> pin_was_high) else $error("rx early");
  chk_status_runs: assert property (
    run_cnt > 4'h1 |-> ##[1:8] $changed(processor_status_clock))
    else $error("status clock stuck");
endmodule : debug_port_monitor
bind debug_jtag_serial_port debug_port_monitor u_debug_port_monitor (
  .clk, .reset, .test_reset_n, .pin_clock, .tdo, .tdo_oe, .serial_debug_out,
  .processor_status_clock, .jtag_mode, .debug_rx_valid);

// >>> sim/dbg_host.sv
// external debugger driving the shared debug pins
`timescale 1ns/100ps
module dbg_host (
  input  wire logic clk,              // bench clock
  input  wire logic tdo,              // test data
  input  wire logic tdo_oe,           // test data enable
  input  wire logic serial_debug_out, // serial data
  output logic      pin_clock,        // test or serial clock
  output logic      tms,              // mode select
  output logic      pin_data_in       // test or serial data
);
  logic hi_tdo; // tdo in high phase
  logic hi_oe;  // enable in high phase
  logic lo_out; // serial out at end of low phase
  initial
  begin
    pin_clock = 1'b0;
    tms = 1'b1;
    pin_data_in = 1'b0;
  end
  // 8 bus cycles a period, 4 high and 4 low; entered just after an edge
  // data is set one cycle ahead of the rise so it never moves with it
  task automatic pulse(input logic t, input logic d);
    tms = t;
    pin_data_in = d;
    @(posedge clk);
    #1 pin_clock = 1'b1;
    repeat (2) @(posedge clk);
    #1 hi_tdo = tdo;
    hi_oe = tdo_oe;
    repeat (2) @(posedge clk);
    #1 pin_clock = 1'b0;
    repeat (3) @(posedge clk);
    #1 lo_out = serial_debug_out;
  endtask : pulse
  // clock stands low, released data line shows the inverse
  task automatic rest(input int n);
    pin_data_in = ~pin_data_in;
    repeat (n) @(posedge clk);
    #1;
  endtask : rest
  task automatic glitch;
    pin_clock = 1'b1;
    @(posedge clk);
    #1 pin_clock = 1'b0;
  endtask : glitch
endmodule : dbg_host

// >>> sim/debug_jtag_serial_port_tb_top.sv
// self-checking bench for the debug and test port
`timescale 1ns/100ps
module debug_jtag_serial_port_tb_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        jtag_select = 1'b1;
  logic        test_reset_n = 1'b1;
  logic [15:0] debug_tx = 16'h0000;
  logic        pin_clock, tms, pin_data_in, tdo, tdo_oe, serial_debug_out;
  logic        processor_status_clock, jtag_mode, debug_rx_valid;
  logic [15:0] debug_rx;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          rx_pulses = 0;
  always #20 clk = ~clk;
  always @(posedge clk)
    if (debug_rx_valid === 1'b1)
      rx_pulses++;
  debug_jtag_serial_port u_debug_jtag_serial_port (.clk, .reset, .jtag_select,
    .test_reset_n, .pin_clock, .tms, .pin_data_in, .debug_tx, .tdo, .tdo_oe,
    .serial_debug_out, .processor_status_clock, .jtag_mode, .debug_rx,
    .debug_rx_valid);
  dbg_host u_dbg_host (.clk, .tdo, .tdo_oe, .serial_debug_out, .pin_clock,
    .tms, .pin_data_in);
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results;
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // reset with a choice, then move the select pin away from it
  task automatic start(input logic sel);
    @(posedge clk) #1;
    reset = 1'b1;
    jtag_select = sel;
    repeat (16) @(posedge clk);
    #1 reset = 1'b0;
    repeat (6) @(posedge clk);
    #1 jtag_select = ~sel;
  endtask : start
  // walk to shift-IR, load bypass, shift bypass, then test reset mid-shift
  task automatic jtag_scan;
    logic [25:0] tms_bits = 26'h0A160DF;
    logic [25:0] tdi_bits = 26'h0083C00;
    logic [25:0] oe_bits = 26'h2383C00;
    logic [25:0] tdo_bits = 26'h0100400;
    start(1'b1);
    check("jtag_mode", 16'(jtag_mode), 16'h0001);
    for (int k = 0; k < 26; k++)
    begin
      u_dbg_host.pulse(tms_bits[k], tdi_bits[k]);
      check("tdo_oe", 16'(u_dbg_host.hi_oe), 16'(oe_bits[k]));
      if (oe_bits[k])
        check("tdo", 16'(u_dbg_host.hi_tdo), 16'(tdo_bits[k]));
    end
    test_reset_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 check("trst oe", 16'(tdo_oe), 16'h0000);
    test_reset_n = 1'b1;
    u_dbg_host.rest(4);
    u_dbg_host.pulse(1'b0, 1'b0);
    u_dbg_host.pulse(1'b0, 1'b0);
    check("idle oe", 16'(u_dbg_host.hi_oe), 16'h0000);
  endtask : jtag_scan
  task automatic send(input logic [15:0] w, output logic [15:0] back);
    for (int i = 15; i >= 0; i--)
    begin
      u_dbg_host.pulse(1'b0, w[i]);
      back[i] = u_dbg_host.lo_out;
    end
  endtask : send
  // two words MSB first after a one-cycle glitch that must be ignored
  task automatic serial_words;
    logic [15:0] got;
    start(1'b0);
    check("jtag_mode", 16'(jtag_mode), 16'h0000);
    u_dbg_host.glitch();
    u_dbg_host.rest(4);
    debug_tx = 16'h3C96;
    send(16'hA5C3, got);
    check("rx word", debug_rx, 16'hA5C3);
    u_dbg_host.rest(8);
    send(16'h5A3C, got);
    check("tx word", got, 16'h3C96);
    check("rx word", debug_rx, 16'h5A3C);
    check("rx count", 16'(rx_pulses), 16'h0002);
  endtask : serial_words
  initial
  begin
    jtag_scan();
    serial_words();
    results();
  end
  // both scenarios take well under a thousand cycles
  initial
  begin
    #(40 * 3000);
    fail_count++;
    results();
  end
endmodule : debug_jtag_serial_port_tb_top
